//--- shared/irqlf_pkg.sv
// constants and types for the first-channel latched event flags
// Behaviour
// - lock flags bits 9,8 latch both edges
// - input signal flag bit 2 both edges
// - compressor signal flags bits 1,0 both edges
// - sixteen firmware flags, rising edge only
// - headphone short flags on rising edge
// - enable done flags bits 5..0 rising edge
// - disable done flags same layout rising edge
// - converter saturate flag bit 12 rising
// - flags hold until one written; reset zero
// - request pin active low, polarity selectable
package irqlf_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned NUM_REGS = 6;
  localparam logic [15:0] ADDR_LOCK_SIG = 16'h1808;
  localparam logic [15:0] ADDR_FW_REQ = 16'h180a;
  localparam logic [15:0] ADDR_SHORT = 16'h180b;
  localparam logic [15:0] ADDR_ON_DONE = 16'h180c;
  localparam logic [15:0] ADDR_OFF_DONE = 16'h180d;
  localparam logic [15:0] ADDR_SATURATE = 16'h180e;
  // mask registers sit 0x40 above the flags; config register after them
  localparam logic [15:0] MASK_OFFSET = 16'h0040;
  localparam logic [15:0] ADDR_CONFIG = 16'h1850;
  localparam logic [15:0] ADDR_RAW = 16'h1851;

  // ****************************************
  // implemented bits per flag register
  // ****************************************
  localparam logic [15:0] IMPL_LOCK_SIG = 16'h0307;
  localparam logic [15:0] IMPL_FW_REQ = 16'hffff;
  localparam logic [15:0] IMPL_SHORT = 16'h033f;
  localparam logic [15:0] IMPL_DONE = 16'h003f;
  localparam logic [15:0] IMPL_SATURATE = 16'h1000;
  // both-edge bits; everything else is rising only
  localparam logic [15:0] BOTH_LOCK_SIG = 16'h0307;
  localparam logic [15:0] FLAG_RESET = 16'h0000;
  // masks reset set, so nothing requests until software opens it
  localparam logic [15:0] MASK_RESET = 16'hffff;
  localparam int unsigned POL_BIT = 0;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } irqlf_bus_req_t;

  typedef struct packed {
    logic [1:0] lock;       // in2, in1
    logic input_sig;
    logic [1:0] comp_sig;   // unit2, unit1
    logic [15:0] fw_req;
    logic [9:0] short_det;  // bit layout as the short register
    logic [5:0] on_done;
    logic [5:0] off_done;
    logic saturate;
  } irqlf_src_t;

endpackage

//--- src/irqlf_flag_reg.sv
// one register of sticky edge-triggered flags with write-one-clear
`timescale 1ns/10ps
module irqlf_flag_reg #(
  parameter int unsigned WIDTH = 16,
  parameter logic [15:0] IMPL = 16'hffff,
  parameter logic [15:0] BOTH = 16'h0000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] src,
  input wire logic clr_en,
  input wire logic [WIDTH-1:0] clr_bits,
  output logic [WIDTH-1:0] flags
);

  typedef struct packed {
    logic [WIDTH-1:0] prev;
    logic [WIDTH-1:0] flags;
  } irqlf_fr_state_t;

  irqlf_fr_state_t st_q;
  irqlf_fr_state_t st_d;
  logic [WIDTH-1:0] evt;

  // the implemented-bit tables are 16 bits wide, so only 16 can work
  if (WIDTH != 16) begin : g_bad_width
    $error("flag register width must be 16");
  end

  // ****************************************
  // per-bit edge detect
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      if (!IMPL[i]) begin : g_none
        assign evt[i] = 1'b0;
      end else if (BOTH[i]) begin : g_both
        assign evt[i] = src[i] ^ st_q.prev[i];
      end else begin : g_rise
        assign evt[i] = src[i] & ~st_q.prev[i];
      end
    end
  endgenerate

  // set beats clear so an event in the clearing cycle is kept
  always_comb begin
    st_d = st_q;
    st_d.prev = src;
    if (clr_en) begin
      st_d.flags = st_q.flags & ~clr_bits;
    end
    st_d.flags = (st_d.flags | evt) & IMPL[WIDTH-1:0];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign flags = st_q.flags;

  held_until_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q.flags[0] && !(clr_en && clr_bits[0])) |=> st_q.flags[0])
    else $error("flag dropped without clear");

  edge_sets_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    (IMPL[0] && src[0] && !$past(src[0])) |=> flags[0])
    else $error("rising edge missed");

endmodule // irqlf_flag_reg

//--- src/irqlf_top.sv
// first-channel latched event flags, masks and request pin
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
module irqlf_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire irqlf_pkg::irqlf_src_t src,
  output logic irq_pin,
  output logic irq_req
);

  typedef struct packed {
    logic [5:0][15:0] mask;
    logic pol;
    logic [15:0] rdata;
    logic req;
    logic pin;
  } irqlf_state_t;

  irqlf_state_t st_q;
  irqlf_state_t st_d;
  irqlf_pkg::irqlf_bus_req_t bus;
  logic [5:0][15:0] flags;
  logic [5:0][15:0] src_vec;
  logic [5:0] clr_sel;
  logic [5:0] mask_sel;
  logic any_req;

  assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  // ****************************************
  // source packing into register bit layout
  // ****************************************
  assign src_vec[0] = {6'h00, src.lock, 5'h00, src.input_sig,
                       src.comp_sig};
  assign src_vec[1] = src.fw_req;
  assign src_vec[2] = {6'h00, src.short_det};
  assign src_vec[3] = {10'h000, src.on_done};
  assign src_vec[4] = {10'h000, src.off_done};
  assign src_vec[5] = {3'h0, src.saturate, 12'h000};

  // address decode for flag clear and mask write
  always_comb begin
    clr_sel = '0;
    mask_sel = '0;
    if (bus.addr == irqlf_pkg::ADDR_LOCK_SIG) begin
      clr_sel[0] = 1'b1;
    end else if (bus.addr == irqlf_pkg::ADDR_FW_REQ) begin
      clr_sel[1] = 1'b1;
    end else if (bus.addr == irqlf_pkg::ADDR_SHORT) begin
      clr_sel[2] = 1'b1;
    end else if (bus.addr == irqlf_pkg::ADDR_ON_DONE) begin
      clr_sel[3] = 1'b1;
    end else if (bus.addr == irqlf_pkg::ADDR_OFF_DONE) begin
      clr_sel[4] = 1'b1;
    end else if (bus.addr == irqlf_pkg::ADDR_SATURATE) begin
      clr_sel[5] = 1'b1;
    end else if (bus.addr == irqlf_pkg::ADDR_LOCK_SIG
                 + irqlf_pkg::MASK_OFFSET) begin
      mask_sel[0] = 1'b1;
    end else if (bus.addr == irqlf_pkg::ADDR_FW_REQ
                 + irqlf_pkg::MASK_OFFSET) begin
      mask_sel[1] = 1'b1;
    end else if (bus.addr == irqlf_pkg::ADDR_SHORT
                 + irqlf_pkg::MASK_OFFSET) begin
      mask_sel[2] = 1'b1;
    end else if (bus.addr == irqlf_pkg::ADDR_ON_DONE
                 + irqlf_pkg::MASK_OFFSET) begin
      mask_sel[3] = 1'b1;
    end else if (bus.addr == irqlf_pkg::ADDR_OFF_DONE
                 + irqlf_pkg::MASK_OFFSET) begin
      mask_sel[4] = 1'b1;
    end else if (bus.addr == irqlf_pkg::ADDR_SATURATE
                 + irqlf_pkg::MASK_OFFSET) begin
      mask_sel[5] = 1'b1;
    end
  end

  // ****************************************
  // flag registers
  // ****************************************
  localparam logic [5:0][15:0] IMPL_TAB = {
    irqlf_pkg::IMPL_SATURATE, irqlf_pkg::IMPL_DONE, irqlf_pkg::IMPL_DONE,
    irqlf_pkg::IMPL_SHORT, irqlf_pkg::IMPL_FW_REQ, irqlf_pkg::IMPL_LOCK_SIG};

  genvar r;
  generate
    for (r = 0; r < 6; r++) begin : g_reg
      irqlf_flag_reg #(
        .WIDTH(irqlf_pkg::DATA_W),
        .IMPL(IMPL_TAB[r]),
        .BOTH((r == 0) ? irqlf_pkg::BOTH_LOCK_SIG : 16'h0000)
      ) u_flags (
        .clk(clk),
        .rst_n(rst_n),
        .src(src_vec[r]),
        .clr_en(bus.wr && clr_sel[r]),
        .clr_bits(bus.wdata),
        .flags(flags[r])
      );
    end
  endgenerate

  // request while any flag is set with its mask bit clear
  always_comb begin
    any_req = 1'b0;
    for (int k = 0; k < 6; k++) begin
      any_req = any_req | (|(flags[k] & ~st_q.mask[k]));
    end
  end

  // ****************************************
  // register state, read mux, request pin
  // ****************************************
  always_comb begin
    st_d = st_q;
    st_d.rdata = '0;
    if (bus.wr) begin
      for (int k = 0; k < 6; k++) begin
        if (mask_sel[k]) begin
          st_d.mask[k] = bus.wdata & IMPL_TAB[k];
        end
      end
      if (bus.addr == irqlf_pkg::ADDR_CONFIG) begin
        st_d.pol = bus.wdata[irqlf_pkg::POL_BIT];
      end
    end
    if (bus.rd) begin
      for (int k = 0; k < 6; k++) begin
        if (clr_sel[k]) begin
          st_d.rdata = flags[k];
        end
        if (mask_sel[k]) begin
          st_d.rdata = st_q.mask[k];
        end
      end
      if (bus.addr == irqlf_pkg::ADDR_CONFIG) begin
        st_d.rdata = {15'h0000, st_q.pol};
      end else if (bus.addr == irqlf_pkg::ADDR_RAW) begin
        st_d.rdata = {15'h0000, st_q.req};
      end
    end
    st_d.req = any_req;
    // pin low when requesting unless inverted; next pol keeps pin and pol
    // in step, else a polarity write leaves one cycle of wrong level
    st_d.pin = any_req ? st_d.pol : ~st_d.pol;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q.mask <= {6{irqlf_pkg::MASK_RESET}};
      st_q.pol <= 1'b0;
      st_q.rdata <= '0;
      st_q.req <= 1'b0;
      st_q.pin <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata = st_q.rdata;
  assign irq_req = st_q.req;
  assign irq_pin = st_q.pin;

  pin_polarity_a: assert property (@(posedge clk) disable iff (!rst_n)
    irq_pin == (irq_req ? st_q.pol : ~st_q.pol))
    else $error("pin level disagrees with request and polarity");

  request_follows_a: assert property (@(posedge clk) disable iff (!rst_n)
    any_req |=> irq_req)
    else $error("request not raised for unmasked flag");

  lock_both_edges_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(src.lock[0]) |=> flags[0][8])
    else $error("lock fall not latched");

  signal_both_edges_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(src.input_sig) |=> flags[0][2])
    else $error("signal detect fall not latched");

  comp_both_edges_a: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(src.comp_sig[1]) |=> flags[0][1])
    else $error("compressor edge not latched");

  short_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(src.short_det[9]) |=> flags[2][9])
    else $error("short edge not latched");

  on_done_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(src.on_done[5]) |=> flags[3][5])
    else $error("enable done not latched");

  off_done_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(src.off_done[0]) |=> flags[4][0])
    else $error("disable done not latched");

  saturate_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(src.saturate) |=> flags[5][12])
    else $error("saturate not latched");

  clear_works_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr && addr == irqlf_pkg::ADDR_FW_REQ && wdata[3]
     && !(src.fw_req[3] && !$past(src.fw_req[3]))) |=> !flags[1][3])
    else $error("write one did not clear flag");

  // ****************************************
  // further per-source and request checks
  // ****************************************
  // second lock input and the rising side of the both-edge sources
  lock_in2_fall_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(src.lock[1]) |=> flags[0][9])
    else $error("second lock fall not latched");

  lock_in2_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(src.lock[1]) |=> flags[0][9])
    else $error("second lock rise not latched");

  lock_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(src.lock[0]) |=> flags[0][8])
    else $error("lock rise not latched");

  signal_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(src.input_sig) |=> flags[0][2])
    else $error("signal detect rise not latched");

  comp_unit1_a: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(src.comp_sig[0]) |=> flags[0][0])
    else $error("first compressor edge not latched");

  fw_top_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(src.fw_req[15]) |=> flags[1][15])
    else $error("top firmware request not latched");

  // a falling request must not set a rising-only flag
  fw_no_fall_a: assert property (@(posedge clk) disable iff (!rst_n)
    ($fell(src.fw_req[15]) && !flags[1][15]) |=> !flags[1][15])
    else $error("firmware flag set on falling edge");

  short_left_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(src.short_det[0]) |=> flags[2][0])
    else $error("first short edge not latched");

  on_done_left_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(src.on_done[0]) |=> flags[3][0])
    else $error("first enable done not latched");

  off_done_top_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(src.off_done[5]) |=> flags[4][5])
    else $error("shared disable done not latched");

  saturate_no_fall_a: assert property (@(posedge clk) disable iff (!rst_n)
    ($fell(src.saturate) && !flags[5][12]) |=> !flags[5][12])
    else $error("saturate flag set on falling edge");

  // a zero in the write data must leave a set flag alone
  zero_write_keeps_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr && clr_sel[0] && !wdata[8] && flags[0][8]) |=> flags[0][8])
    else $error("zero write cleared a flag");

  masked_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    !any_req |=> !irq_req)
    else $error("request raised with no unmasked flag");

  // read data only stand in the cycle after a read strobe
  rdata_idle_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    !rd |=> (rdata == 16'h0000))
    else $error("read data not zero outside a read");

  cov_request: cover property (@(posedge clk) disable iff (!rst_n)
    $rose(irq_req));
  cov_clear: cover property (@(posedge clk) disable iff (!rst_n)
    wr && clr_sel[1] && |wdata);
  cov_inverted: cover property (@(posedge clk) disable iff (!rst_n)
    st_q.pol && irq_pin);
  cov_set_wins: cover property (@(posedge clk) disable iff (!rst_n)
    wr && clr_sel[1] && wdata[0] && src.fw_req[0] && !$past(src.fw_req[0]));
  cov_lock_fall: cover property (@(posedge clk) disable iff (!rst_n)
    $fell(src.lock[0]));

endmodule // irqlf_top

//--- sim/irqlf_host_model.sv
// host-side model that decodes the request pin into a request level
`timescale 1ns/10ps
module irqlf_host_model (
  input wire logic irq_pin,
  input wire logic pol,
  output logic req_seen
);
  // host decodes by the polarity it programmed, so a swapped pin shows up
  assign req_seen = pol ? irq_pin : ~irq_pin;
endmodule // irqlf_host_model

//--- sim/irqlf_top_test.sv
// self-checking bench for the first-channel latched event flags
`timescale 1ns/10ps
module irqlf_top_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  irqlf_pkg::irqlf_src_t src = '0;
  logic irq_pin;
  logic irq_req;
  logic pol = 1'b0;
  logic req_seen;
  int n_fail = 0;
  int check_count = 0;
  logic [15:0] fa [6] = '{irqlf_pkg::ADDR_LOCK_SIG, irqlf_pkg::ADDR_FW_REQ,
    irqlf_pkg::ADDR_SHORT, irqlf_pkg::ADDR_ON_DONE,
    irqlf_pkg::ADDR_OFF_DONE, irqlf_pkg::ADDR_SATURATE};
  logic [15:0] fx [6] = '{16'h0307, 16'hffff, 16'h033f, 16'h003f,
    16'h003f, 16'h1000};

  // ****************************************
  // clock, design and host
  // ****************************************
  // free-running 8 ns clock
  always #4 clk = ~clk;

  irqlf_top i_dut (
    .clk(clk),
    .rst_n(rst_n),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata(rdata),
    .src(src),
    .irq_pin(irq_pin),
    .irq_req(irq_req)
  );

  irqlf_host_model i_host (
    .irq_pin(irq_pin),
    .pol(pol),
    .req_seen(req_seen)
  );

  // ****************************************
  // access tasks
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  // flag lands one cycle after the source, request one more; wait three
  task automatic set_src(input irqlf_pkg::irqlf_src_t s);
    @(posedge clk);
    src <= s;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  // main sequence; each test leaves all flags clear
  initial begin
    irqlf_pkg::irqlf_src_t s;
    s = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) rd_chk(fa[i], 16'h0000);
    rd_chk(16'h1900, 16'h0000);
    $display("test reset values done");
    s.lock = 2'h3;
    s.input_sig = 1'b1;
    s.comp_sig = 2'h3;
    set_src(s);
    rd_chk(fa[0], 16'h0307);
    wr_reg(fa[0], 16'h0000);
    rd_chk(fa[0], 16'h0307);
    wr_reg(fa[0], 16'h0100);
    rd_chk(fa[0], 16'h0207);
    wr_reg(fa[0], 16'hffff);
    s = '0;
    set_src(s);
    rd_chk(fa[0], 16'h0307);
    wr_reg(fa[0], 16'hffff);
    rd_chk(fa[0], 16'h0000);
    $display("test both-edge flags done");
    s.fw_req = 16'hffff;
    s.short_det = 10'h33f;
    s.on_done = 6'h3f;
    s.off_done = 6'h3f;
    s.saturate = 1'b1;
    set_src(s);
    for (int i = 1; i < 6; i++) begin
      rd_chk(fa[i], fx[i]);
      wr_reg(fa[i], 16'hffff);
    end
    s = '0;
    set_src(s);
    for (int i = 1; i < 6; i++) rd_chk(fa[i], 16'h0000);
    $display("test rising-only flags done");
    chk({15'h0000, irq_req}, 16'h0000);
    wr_reg(fa[5] + irqlf_pkg::MASK_OFFSET, 16'hefff);
    s.saturate = 1'b1;
    set_src(s);
    chk({15'h0000, irq_req}, 16'h0001);
    chk({15'h0000, irq_pin}, 16'h0000);
    chk({15'h0000, req_seen}, 16'h0001);
    rd_chk(irqlf_pkg::ADDR_RAW, 16'h0001);
    @(posedge clk);
    #1;
    chk(rdata, 16'h0000);
    wr_reg(irqlf_pkg::ADDR_CONFIG, 16'h0001);
    pol <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({15'h0000, irq_pin}, 16'h0001);
    chk({15'h0000, req_seen}, 16'h0001);
    wr_reg(fa[5] + irqlf_pkg::MASK_OFFSET, 16'hffff);
    repeat (2) @(posedge clk);
    #1;
    chk({15'h0000, irq_req}, 16'h0000);
    chk({15'h0000, irq_pin}, 16'h0000);
    wr_reg(fa[5], 16'h1000);
    rd_chk(fa[5], 16'h0000);
    $display("test request pin done");
    // event and clear in one cycle: the set must win
    s.fw_req = 16'h0001;
    @(posedge clk);
    addr <= irqlf_pkg::ADDR_FW_REQ;
    wdata <= 16'h0001;
    wr <= 1'b1;
    src <= s;
    @(posedge clk);
    wr <= 1'b0;
    rd_chk(fa[1], 16'h0001);
    wr_reg(fa[1], 16'h0001);
    rd_chk(fa[1], 16'h0000);
    $display("test clear collision done");
    // mid-run reset must bring masks, polarity and flags back to idle
    wr_reg(fa[1] + irqlf_pkg::MASK_OFFSET, 16'h0000);
    rd_chk(fa[1] + irqlf_pkg::MASK_OFFSET, 16'h0000);
    rd_chk(irqlf_pkg::ADDR_CONFIG, 16'h0001);
    s = '0;
    @(posedge clk);
    src <= s;
    rst_n <= 1'b0;
    pol <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk({15'h0000, irq_pin}, 16'h0001);
    chk({15'h0000, req_seen}, 16'h0000);
    chk({15'h0000, irq_req}, 16'h0000);
    rd_chk(fa[1] + irqlf_pkg::MASK_OFFSET, 16'hffff);
    rd_chk(irqlf_pkg::ADDR_CONFIG, 16'h0000);
    rd_chk(fa[1], 16'h0000);
    $display("test mid-run reset done");
    print_verdict();
  end

  // watchdog well beyond the roughly 130 cycles the tests take
  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    print_verdict();
  end
endmodule // irqlf_top_test
